// >>> src/rmvc_pkg.sv
// Constants shared by the reset, mode and vector control block.
// Assumes a 100 MHz system clock and a 2 MHz bus E clock.
package rmvc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_NS = 10;
	localparam int E_CLK_NS = 500;
	localparam int E_DIV_CYC = E_CLK_NS / SYS_CLK_NS;
	localparam int POR_E_CYCLES = 4064;
	localparam int DRIVE_E_CYCLES = 4;
	localparam int SAMPLE_E_CYCLES = 2;

	// ----------------------------------------------------------------
	// Register map, 8-bit data
	// ----------------------------------------------------------------
	localparam logic [2:0] ADDR_PRIO_MODE = 3'h0;
	localparam logic [2:0] ADDR_OPTION = 3'h1;
	localparam logic [2:0] ADDR_NVM_PROG = 3'h2;
	localparam logic [2:0] ADDR_STATUS = 3'h3;
	localparam logic [2:0] ADDR_SCRATCH = 3'h4;

	// Priority and mode register fields
	localparam int BIT_BOOT = 7;
	localparam int BIT_SPECIAL_MODE_BIT = 6;
	localparam int BIT_MDA = 5;
	localparam logic [3:0] PSEL_RST = 4'h5;

	// Option register fields
	localparam int BIT_IRQ_EDGE = 0;
	localparam int BIT_DLY = 1;
	localparam int BIT_CME = 2;

	// Status register fields
	localparam int BIT_ST_WDOG = 0;
	localparam int BIT_ST_CMF = 1;
	localparam int BIT_ST_WDEN = 2;

	localparam int NVM_W = 4;
	localparam logic [NVM_W-1:0] NVM_PROG_RST = 4'h0;

	// ----------------------------------------------------------------
	// Vectors
	// ----------------------------------------------------------------
	localparam logic [7:0] VEC_HI_NORMAL = 8'hFF;
	localparam logic [7:0] VEC_HI_SPECIAL = 8'hBF;
	localparam logic [7:0] VEC_LO_PRIMARY = 8'hFE;
	localparam logic [7:0] VEC_LO_CMF = 8'hFC;
	localparam logic [7:0] VEC_LO_WDOG = 8'hFA;
	localparam logic [15:0] AREA_NORMAL = 16'hFFC0;
	localparam logic [15:0] AREA_SPECIAL = 16'hBFC0;

	typedef enum logic [2:0] {
		RMVC_POR,
		RMVC_DRIVE,
		RMVC_SAMPLE,
		RMVC_PIN_WAIT,
		RMVC_RUN
	} rmvc_state_t;

endpackage

// >>> src/rmvc_top.sv
// Reset sequencer, mode latch and reset vector selection.
// Assumes the pin buffer resolves rst_pin_o/rst_pin_oe_o and that all
// inputs are synchronous to sys_clk_i.
//
// Our own choices: the register offsets and the address-and-strobe port.
module rmvc_top
	import rmvc_pkg::*;
#(
	parameter int POR_CYCLES = POR_E_CYCLES,
	parameter int E_DIV = E_DIV_CYC
) (
	input wire logic sys_clk_i,
	input wire logic srst_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic rst_pin_i,
	output logic rst_pin_o,
	output logic rst_pin_oe_o,
	input wire logic mode_select_a_pin_i,
	input wire logic mode_select_b_pin_i,
	input wire logic wdog_timeout_i,
	input wire logic clk_fail_i,
	input wire logic nv_wdog_enable_i,
	output logic cpu_reset_o,
	output logic [15:0] reset_vector_o,
	output logic [15:0] vector_area_o,
	output logic vector_external_o,
	output logic boot_rom_fetch_o,
	output logic [3:0] prio_select_o,
	output logic irq_edge_o,
	output logic osc_startup_delay_enable_o,
	output logic clock_failure_detect_enable_o,
	output logic [NVM_W-1:0] nvm_prog_o,
	output logic software_watchdog_enable_o
);

	// ----------------------------------------------------------------
	// E clock enable
	// ----------------------------------------------------------------
	logic [15:0] div_cnt;
	logic e_tick;
	rmvc_state_t state;
	rmvc_state_t next_state;

	// Restarted on every phase change so phase lengths are exact
	always_ff @(posedge sys_clk_i) begin
		if (srst_i || next_state != state || div_cnt == 16'(E_DIV - 1)) begin
			div_cnt <= 16'h0000;
		end else begin
			div_cnt <= div_cnt + 16'h0001;
		end
	end

	assign e_tick = (div_cnt == 16'(E_DIV - 1));

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	logic [11:0] e_cnt;
	logic cause_wdog;
	logic cause_cmf;
	logic wdog_en;
	logic clock_failure_detect_enable;
	logic wdog_evt;
	logic cmf_evt;
	logic pin_evt;
	logic seq_done;

	assign wdog_evt = wdog_en && wdog_timeout_i;
	assign cmf_evt = clock_failure_detect_enable && clk_fail_i;
	assign pin_evt = !rst_pin_i;

	always_comb begin
		next_state = state;
		seq_done = 1'b0;
		case (state)
			RMVC_POR: begin
				// Power-on hold, counted in E cycles
				seq_done = e_tick && e_cnt == 12'(POR_CYCLES - 1);
				if (seq_done) begin
					next_state = RMVC_PIN_WAIT;
				end
			end
			RMVC_DRIVE: begin
				seq_done = e_tick && e_cnt == 12'(DRIVE_E_CYCLES - 1);
				if (seq_done) begin
					next_state = RMVC_SAMPLE;
				end
			end
			RMVC_SAMPLE: begin
				seq_done = e_tick && e_cnt == 12'(SAMPLE_E_CYCLES - 1);
				if (seq_done) begin
					next_state = RMVC_PIN_WAIT;
				end
			end
			RMVC_PIN_WAIT: begin
				if (rst_pin_i) begin
					next_state = RMVC_RUN;
				end
			end
			RMVC_RUN: begin
				// Every source enters the same sequence
				if (wdog_evt || cmf_evt || pin_evt) begin
					next_state = RMVC_DRIVE;
				end
			end
			default: next_state = RMVC_POR;
		endcase
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			state <= RMVC_POR;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i || next_state != state) begin
			e_cnt <= 12'h000;
		end else if (e_tick) begin
			e_cnt <= e_cnt + 12'h001;
		end
	end

	// Cause latch: events set, external verdict clears, clear wins
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			cause_wdog <= 1'b0;
			cause_cmf <= 1'b0;
		end else begin
			if (state == RMVC_RUN && next_state == RMVC_DRIVE) begin
				cause_wdog <= wdog_evt;
				cause_cmf <= cmf_evt;
			end else if (state == RMVC_SAMPLE && seq_done && !rst_pin_i) begin
				cause_wdog <= 1'b0;
				cause_cmf <= 1'b0;
			end else if (state == RMVC_DRIVE) begin
				cause_wdog <= cause_wdog | wdog_evt;
				cause_cmf <= cause_cmf | cmf_evt;
			end
		end
	end

	// Chip reset ends one cycle after capture, with the new vector
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rst_pin_oe_o <= 1'b1;
			rst_pin_o <= 1'b0;
			cpu_reset_o <= 1'b1;
		end else begin
			rst_pin_oe_o <= next_state == RMVC_POR ||
				next_state == RMVC_DRIVE;
			rst_pin_o <= 1'b0;
			cpu_reset_o <= state != RMVC_RUN || next_state != RMVC_RUN;
		end
	end

	// ----------------------------------------------------------------
	// Mode pipeline and latch
	// ----------------------------------------------------------------
	logic mode_a_pipe;
	logic mode_b_pipe;
	logic boot_rom_enable;
	logic special_mode_bit;
	logic mode_a_bit;

	always_ff @(posedge sys_clk_i) begin
		mode_a_pipe <= mode_select_a_pin_i;
		mode_b_pipe <= mode_select_b_pin_i;
	end

	// Pipelined value is a cycle older than the rising pin
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			boot_rom_enable <= 1'b0;
			special_mode_bit <= 1'b0;
			mode_a_bit <= 1'b0;
		end else if (state == RMVC_PIN_WAIT && rst_pin_i) begin
			boot_rom_enable <= !mode_b_pipe && !mode_a_pipe;
			special_mode_bit <= !mode_b_pipe;
			mode_a_bit <= mode_a_pipe;
		end
	end

	// Nonvolatile options take hold while the chip is in reset
	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			wdog_en <= 1'b0;
		end else if (state != RMVC_RUN) begin
			wdog_en <= nv_wdog_enable_i;
		end
	end

	// ----------------------------------------------------------------
	// Vector selection
	// ----------------------------------------------------------------
	logic [7:0] vec_hi;
	logic [7:0] vec_lo;

	assign vec_hi = special_mode_bit ? VEC_HI_SPECIAL : VEC_HI_NORMAL;
	assign vec_lo = cause_cmf ? VEC_LO_CMF :
		cause_wdog ? VEC_LO_WDOG :
		VEC_LO_PRIMARY;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			reset_vector_o <= {VEC_HI_NORMAL, VEC_LO_PRIMARY};
			vector_area_o <= AREA_NORMAL;
			vector_external_o <= 1'b0;
			boot_rom_fetch_o <= 1'b0;
		end else begin
			reset_vector_o <= {vec_hi, vec_lo};
			vector_area_o <= special_mode_bit ? AREA_SPECIAL : AREA_NORMAL;
			vector_external_o <= special_mode_bit && mode_a_bit;
			boot_rom_fetch_o <= boot_rom_enable;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [3:0] psel;
	logic irq_edge;
	logic dly;
	logic [NVM_W-1:0] nvm_prog;
	logic [7:0] scratch;
	logic chip_rst;

	// Every control register follows the whole-chip reset
	assign chip_rst = srst_i || cpu_reset_o;

	always_ff @(posedge sys_clk_i) begin
		if (chip_rst) begin
			psel <= PSEL_RST;
		end else if (wr_i && addr_i == ADDR_PRIO_MODE) begin
			psel <= wdata_i[3:0];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (chip_rst) begin
			irq_edge <= 1'b0;
			dly <= 1'b1;
			clock_failure_detect_enable <= 1'b0;
		end else if (wr_i && addr_i == ADDR_OPTION) begin
			irq_edge <= wdata_i[BIT_IRQ_EDGE];
			dly <= wdata_i[BIT_DLY];
			clock_failure_detect_enable <= wdata_i[BIT_CME];
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (chip_rst) begin
			nvm_prog <= NVM_PROG_RST;
		end else if (wr_i && addr_i == ADDR_NVM_PROG) begin
			nvm_prog <= wdata_i[NVM_W-1:0];
		end
	end

	// Scratch is left alone by reset; its content is undefined
	always_ff @(posedge sys_clk_i) begin
		if (wr_i && addr_i == ADDR_SCRATCH) begin
			scratch <= wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				ADDR_PRIO_MODE: rdata_o <= {boot_rom_enable, special_mode_bit,
					mode_a_bit, 1'b0, psel};
				ADDR_OPTION: rdata_o <= {5'h00, clock_failure_detect_enable, dly, irq_edge};
				ADDR_NVM_PROG: rdata_o <= 8'(nvm_prog);
				ADDR_STATUS: rdata_o <= {5'h00, wdog_en, cause_cmf, cause_wdog};
				ADDR_SCRATCH: rdata_o <= scratch;
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (srst_i) begin
			prio_select_o <= PSEL_RST;
			irq_edge_o <= 1'b0;
			osc_startup_delay_enable_o <= 1'b1;
			clock_failure_detect_enable_o <= 1'b0;
			nvm_prog_o <= NVM_PROG_RST;
			software_watchdog_enable_o <= 1'b0;
		end else begin
			prio_select_o <= psel;
			irq_edge_o <= irq_edge;
			osc_startup_delay_enable_o <= dly;
			clock_failure_detect_enable_o <= clock_failure_detect_enable;
			nvm_prog_o <= nvm_prog;
			software_watchdog_enable_o <= wdog_en;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (srst_i);

	logic [15:0] drive_len;

	always_ff @(posedge sys_clk_i) begin
		if (srst_i || state != RMVC_DRIVE) begin
			drive_len <= 16'h0000;
		end else begin
			drive_len <= drive_len + 16'h0001;
		end
	end

	sequence s_in_reset;
		cpu_reset_o ##1 cpu_reset_o;
	endsequence

	sequence s_enter_drive;
		state == RMVC_RUN && (wdog_evt || cmf_evt);
	endsequence

	a_psel_default: assert property (
		s_in_reset |-> psel == PSEL_RST)
		else $error("priority select not at reset default");
	a_irq_level: assert property (
		s_in_reset |-> !irq_edge && irq_edge_o == $past(irq_edge))
		else $error("interrupt input not level sensitive in reset");
	a_dly_cme_reset: assert property (
		s_in_reset |-> dly && !clock_failure_detect_enable && nvm_prog == NVM_PROG_RST)
		else $error("option or programming defaults wrong in reset");
	a_mode_capture: assert property (
		state == RMVC_PIN_WAIT && rst_pin_i |=>
			special_mode_bit == !$past(mode_b_pipe) &&
			mode_a_bit == $past(mode_a_pipe))
		else $error("mode bits differ from captured pins");
	a_internal_reset: assert property (
		s_enter_drive |=> rst_pin_oe_o && cpu_reset_o ##1 rst_pin_oe_o)
		else $error("internal source did not drive the reset pin");
	a_drive_len: assert property (
		state == RMVC_DRIVE && next_state == RMVC_SAMPLE |->
			drive_len == 16'(DRIVE_E_CYCLES * E_DIV - 1))
		else $error("reset pin drive length wrong");
	a_sample_clear: assert property (
		state == RMVC_SAMPLE && seq_done && !rst_pin_i |=>
			!cause_wdog && !cause_cmf)
		else $error("cause not cleared on external verdict");
	a_vec_prio: assert property (
		$fell(cpu_reset_o) && $past(cause_cmf) |->
			reset_vector_o[7:0] == VEC_LO_CMF)
		else $error("clock-failure vector not chosen");
	a_vec_primary: assert property (
		$fell(cpu_reset_o) && !$past(cause_cmf) && !$past(cause_wdog) |->
			reset_vector_o[7:0] == VEC_LO_PRIMARY)
		else $error("primary vector not chosen by default");
	a_disabled_src: assert property (
		(state == RMVC_RUN && !wdog_en && !clock_failure_detect_enable && rst_pin_i) [*2] |=>
			state == RMVC_RUN)
		else $error("disabled source started a reset");
	a_release_bound: assert property (
		state == RMVC_SAMPLE && rst_pin_i |->
			##[1:200] state != RMVC_SAMPLE)
		else $error("sample phase did not end");
endmodule

// >>> test/rmvc_pin_model.sv
// External reset circuitry sharing the pulled-up reset pin.
// Assumes the bench calls hold_low to pull the pin low by hand.
module rmvc_pin_model (
	input wire logic sys_clk_i,
	input wire logic rst_pin_oe_i,
	input wire logic rst_pin_drv_i,
	output logic rst_pin_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic ext_hold = 1'b0;

	// Pull-up wins unless a party pulls low
	assign rst_pin_o = (rst_pin_oe_i && !rst_pin_drv_i) || ext_hold ? 1'b0 : 1'b1;

	task automatic hold_low(input int n);
		@(posedge sys_clk_i);
		ext_hold <= 1'b1;
		repeat (n) @(posedge sys_clk_i);
		ext_hold <= 1'b0;
	endtask
endmodule

// >>> test/rmvc_top_tb.sv
// Self-checking bench for the reset, mode and vector control block.
// Assumes shortened power-on and E clock counts and a pulled-up pin.
module rmvc_top_tb;
	import rmvc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int POR = 8;
	localparam int ED = 4;
	logic sys_clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic [2:0] addr_i = 3'h0;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0, rd_i = 1'b0;
	logic mode_select_a_pin_i = 1'b0, mode_select_b_pin_i = 1'b1;
	logic wdog_timeout_i = 1'b0, clk_fail_i = 1'b0;
	logic nv_wdog_enable_i = 1'b1;
	wire logic rst_pin_i;
	logic [7:0] rdata_o;
	logic rst_pin_o, rst_pin_oe_o, cpu_reset_o, vector_external_o;
	logic boot_rom_fetch_o, irq_edge_o, osc_startup_delay_enable_o;
	logic clock_failure_detect_enable_o, software_watchdog_enable_o;
	logic [15:0] reset_vector_o, vector_area_o;
	logic [3:0] prio_select_o;
	logic [NVM_W-1:0] nvm_prog_o;
	int fail_count = 0;
	int checks = 0;

	rmvc_top #(
		.POR_CYCLES(POR),
		.E_DIV(ED)
	) rmvc_top_inst (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.addr_i(addr_i),
		.wdata_i(wdata_i),
		.wr_i(wr_i),
		.rd_i(rd_i),
		.rdata_o(rdata_o),
		.rst_pin_i(rst_pin_i),
		.rst_pin_o(rst_pin_o),
		.rst_pin_oe_o(rst_pin_oe_o),
		.mode_select_a_pin_i(mode_select_a_pin_i),
		.mode_select_b_pin_i(mode_select_b_pin_i),
		.wdog_timeout_i(wdog_timeout_i),
		.clk_fail_i(clk_fail_i),
		.nv_wdog_enable_i(nv_wdog_enable_i),
		.cpu_reset_o(cpu_reset_o),
		.reset_vector_o(reset_vector_o),
		.vector_area_o(vector_area_o),
		.vector_external_o(vector_external_o),
		.boot_rom_fetch_o(boot_rom_fetch_o),
		.prio_select_o(prio_select_o),
		.irq_edge_o(irq_edge_o),
		.osc_startup_delay_enable_o(osc_startup_delay_enable_o),
		.clock_failure_detect_enable_o(clock_failure_detect_enable_o),
		.nvm_prog_o(nvm_prog_o),
		.software_watchdog_enable_o(software_watchdog_enable_o)
	);
	rmvc_pin_model rmvc_pin_model_inst (
		.sys_clk_i(sys_clk_i),
		.rst_pin_oe_i(rst_pin_oe_o),
		.rst_pin_drv_i(rst_pin_o),
		.rst_pin_o(rst_pin_i)
	);

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// --------
	// Tasks
	// --------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rdc(input logic [2:0] a, input logic [7:0] e,
		input string what);
		@(posedge sys_clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1 chk({8'h00, rdata_o}, {8'h00, e}, what);
	endtask

	task automatic wait_run();
		int n;
		n = 0;
		while (cpu_reset_o !== 1'b0 && n < 3000) begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		chk(n < 3000, 1'b1, "reset never released");
	endtask

	task automatic do_reset(input logic b, input logic a, input logic nv);
		int n;
		@(posedge sys_clk_i);
		srst_i <= 1'b1;
		mode_select_b_pin_i <= b;
		mode_select_a_pin_i <= a;
		nv_wdog_enable_i <= nv;
		repeat (7) @(posedge sys_clk_i);
		wr(ADDR_OPTION, 8'h07);
		@(posedge sys_clk_i);
		srst_i <= 1'b0;
		n = 0;
		#1;
		while (rst_pin_oe_o === 1'b1 && n < 200) begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		chk(n >= POR * ED && n <= POR * ED + 3, 1'b1, "power-on drive");
		wait_run();
	endtask

	task automatic chk_defaults();
		chk(prio_select_o, PSEL_RST, "priority select");
		chk(irq_edge_o, 1'b0, "irq edge mode");
		chk(osc_startup_delay_enable_o, 1'b1, "start-up delay");
		chk(clock_failure_detect_enable_o, 1'b0, "clock check on");
		chk(nvm_prog_o, NVM_PROG_RST, "programming controls");
		rdc(ADDR_OPTION, 8'h02, "option register");
	endtask

	task automatic pulse(input logic w, input logic c);
		@(posedge sys_clk_i);
		wdog_timeout_i <= w;
		clk_fail_i <= c;
		@(posedge sys_clk_i);
		wdog_timeout_i <= 1'b0;
		clk_fail_i <= 1'b0;
	endtask

	task automatic quiet(input logic w, input logic c);
		int n;
		pulse(w, c);
		n = 0;
		repeat (20) begin
			@(posedge sys_clk_i);
			#1 n += int'(rst_pin_oe_o === 1'b1 || cpu_reset_o !== 1'b0);
		end
		chk(16'(n), 16'h0000, "disabled source acted");
	endtask

	task automatic ireset(input logic w, input logic c, input int hold,
		input logic [7:0] lo);
		int n;
		logic [7:0] hi;
		pulse(w, c);
		hi = mode_select_b_pin_i ? VEC_HI_NORMAL : VEC_HI_SPECIAL;
		if (hold > 0) begin
			fork
				rmvc_pin_model_inst.hold_low(hold);
			join_none
		end
		n = 0;
		#1;
		while (rst_pin_oe_o !== 1'b1 && n < 10) begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		chk(cpu_reset_o, 1'b1, "chip not in reset");
		chk(rst_pin_o, 1'b0, "pin drive level");
		n = 0;
		while (rst_pin_oe_o === 1'b1 && n < 100) begin
			@(posedge sys_clk_i);
			#1 n++;
		end
		chk(16'(n), 16'(4 * ED), "pin drive length");
		wait_run();
		chk(reset_vector_o, {hi, lo}, "reset vector");
		rdc(ADDR_STATUS, {5'h0, nv_wdog_enable_i, c && hold == 0,
			w && hold == 0}, "cause status");
	endtask

	function automatic logic [7:0] exp_reg(input logic [2:0] a,
		input logic [7:0] v);
		logic b;
		logic m;
		b = mode_select_b_pin_i;
		m = mode_select_a_pin_i;
		case (a)
			ADDR_PRIO_MODE: return {!b && !m, !b, m, 1'b0, v[3:0]};
			ADDR_OPTION: return {5'h00, v[2:0]};
			ADDR_NVM_PROG: return {4'h0, v[3:0]};
			default: return v;
		endcase
	endfunction

	// --------
	// Tests
	// --------
	initial begin
		logic sp;
		logic [2:0] a3;
		logic [7:0] d;
		logic [2:0] amap [4];
		amap = '{ADDR_PRIO_MODE, ADDR_OPTION, ADDR_NVM_PROG, ADDR_SCRATCH};
		void'($urandom(32'h9133));
		do_reset(1'b1, 1'b0, 1'b1);
		chk_defaults();
		chk(software_watchdog_enable_o, 1'b1, "watchdog enable");
		rdc(ADDR_STATUS, 8'h04, "status after power-on");
		wr(ADDR_STATUS, 8'hFF);
		rdc(ADDR_STATUS, 8'h04, "status written");
		for (int a = 5; a < 8; a++) begin
			rdc(3'(a), 8'h00, "unmapped read");
		end
		$display("defaults done");
		for (int m = 0; m < 4; m++) begin
			sp = !m[1];
			do_reset(m[1], m[0], 1'b1);
			rdc(ADDR_PRIO_MODE, {sp && !m[0], sp, m[0], 1'b0, PSEL_RST},
				"mode bits");
			chk(reset_vector_o, sp ? 16'hBFFE : 16'hFFFE, "primary");
			chk(vector_area_o, sp ? AREA_SPECIAL : AREA_NORMAL, "area");
			chk(vector_external_o, sp && m[0], "external fetch");
			chk(boot_rom_fetch_o, sp && !m[0], "boot rom fetch");
			@(posedge sys_clk_i);
			mode_select_b_pin_i <= !m[1];
			mode_select_a_pin_i <= !m[0];
			rdc(ADDR_PRIO_MODE, {sp && !m[0], sp, m[0], 1'b0, PSEL_RST},
				"mode bits moved");
			@(posedge sys_clk_i);
			mode_select_b_pin_i <= m[1];
			mode_select_a_pin_i <= m[0];
			ireset(1'b1, 1'b0, 0, VEC_LO_WDOG);
		end
		$display("modes done");
		quiet(1'b0, 1'b1);
		wr(ADDR_OPTION, 8'h06);
		rdc(ADDR_OPTION, 8'h06, "option write");
		ireset(1'b0, 1'b1, 0, VEC_LO_CMF);
		chk(clock_failure_detect_enable_o, 1'b0, "enable after");
		wr(ADDR_OPTION, 8'h06);
		ireset(1'b1, 1'b1, 0, VEC_LO_CMF);
		ireset(1'b1, 1'b0, 60, VEC_LO_PRIMARY);
		ireset(1'b0, 1'b0, 2, VEC_LO_PRIMARY);
		$display("causes done");
		do_reset(1'b1, 1'b1, 1'b0);
		chk(software_watchdog_enable_o, 1'b0, "watchdog off");
		quiet(1'b1, 1'b0);
		$display("disable done");
		for (int i = 0; i < 16; i++) begin
			a3 = amap[$urandom % 4];
			d = 8'($urandom);
			wr(a3, d);
			rdc(a3, exp_reg(a3, d), "register readback");
		end
		do_reset(1'b1, 1'b1, 1'b1);
		chk_defaults();
		$display("registers done");
		close_out();
	end

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		close_out();
	end
endmodule
